//--- core/kis_sync3.sv
// kis_sync3: three-flop synchroniser with agreement filter for a pin input
// assumes: the input is asynchronous to clk_i; output is a clean level
`timescale 1ns/1ps
`default_nettype none
module kis_sync3 #(
   parameter logic RST_VAL = 1'b1
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // pin side
   input wire logic pin_i,
   // filtered level
   output logic level_o
);
   logic s1_r, s2_r, s3_r, lvl_r;
   logic s1_nxt, s2_nxt, s3_nxt, lvl_nxt;

   // shift chain; level moves only when stages two and three agree
   always_comb
   begin
      s1_nxt = pin_i;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
   end

   // registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
         lvl_r <= RST_VAL;
      end
      else if (ce_i)
      begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         lvl_r <= lvl_nxt;
      end
   end

   assign level_o = lvl_r;
endmodule // kis_sync3
`default_nettype wire

//--- core/kis_top.sv
// kis_top: interrupt status, rate control and interrupt pin of a keypad scanner
// assumes: debounce, key fifo and configuration logic share clk_i; debounce feeds pulses, fifo and configuration feed levels
//
// Notes on behaviour
// - top status bit shows interrupt asserted
// - alert and key flags report cause, both
// - rate zero: pin is general-purpose output
// - pin mode still updates flags every cycle
// - key interrupt every Nth cycle if new
// - status bits read-only, writes ignored
// - read clears alert, keeps key interrupt
// - key interrupt clears when fifo empties
// - enabled alert falling edge raises interrupt
// - alert timing bit: immediate or scan timing
`timescale 1ns/1ps
`default_nettype none
module kis_top
(
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // register port
   input wire kis_pkg::kis_req_s req_i,
   output logic [7:0] rdata_o,
   // key scan side
   input wire logic dbc_end_i,
   input wire logic key_new_i,
   input wire logic fifo_empty_i,
   // configuration and ports register bits
   input wire logic alert_int_en_i,
   input wire logic alert_int_now_i,
   input wire logic gpo_level_i,
   // alert pin
   input wire logic alert_pin_i,
   // interrupt pin, open drain
   output logic int_pin_o,
   output logic int_oe_o
);
   import kis_pkg::*;

   logic alert_lvl;
   logic alert_lvl_r, alert_lvl_nxt;
   logic fifo_empty_q_r, fifo_empty_q_nxt;
   logic [KIS_RATE_W-1:0] rate_r, rate_nxt;
   logic [KIS_RATE_W-1:0] cnt_r, cnt_nxt;
   logic [KIS_RATE_W-1:0] eff_m1;
   kis_cause_s flag_r, flag_nxt;
   kis_cause_s pend_r, pend_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic oe_r, oe_nxt;
   logic hit, alert_fall, fifo_rise, boundary, key_set, alert_set;

   // alert pin synchroniser
   kis_sync3 #(.RST_VAL(1'b1)) u_alert_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .pin_i(alert_pin_i),
      .level_o(alert_lvl)
   );

   // event decode
   always_comb
   begin
      hit = (req_i.addr == KIS_INT_REG_ADDR);
      alert_fall = alert_lvl_r && !alert_lvl;
      fifo_rise = fifo_empty_i && !fifo_empty_q_r;
      eff_m1 = ((rate_r == KIS_RATE_GPO) ? KIS_RATE_ONE : rate_r) - KIS_RATE_ONE;
      boundary = dbc_end_i && (cnt_r >= eff_m1);
      key_set = boundary && (pend_r.key || key_new_i);
      // enabled edge, now or at boundary
      alert_set = (alert_fall && alert_int_en_i && alert_int_now_i)
                  || (boundary && (pend_r.alert
                      || (alert_fall && alert_int_en_i)));
   end

   // next state of counters, flags and pin
   always_comb
   begin
      alert_lvl_nxt = alert_lvl;
      fifo_empty_q_nxt = fifo_empty_i;
      rate_nxt = rate_r;
      cnt_nxt = cnt_r;
      pend_nxt = pend_r;
      flag_nxt = flag_r;
      rdata_nxt = rdata_r;
      // only the rate field is writable
      // status bits ignore writes
      if (req_i.wr && hit)
         rate_nxt = req_i.wdata[KIS_RATE_LSB +: KIS_RATE_W];
      // debounce cycle counter
      if (dbc_end_i)
         cnt_nxt = boundary ? '0 : cnt_r + KIS_RATE_ONE;
      // collect causes within an interval
      if (boundary)
         pend_nxt.key = 1'b0;
      else if (key_new_i && dbc_end_i)
         pend_nxt.key = 1'b1;
      if (boundary)
         pend_nxt.alert = 1'b0;
      else if (alert_fall && alert_int_en_i && !alert_int_now_i)
         pend_nxt.alert = 1'b1;
      // key flag cleared by fifo empty
      if (fifo_rise)
         flag_nxt.key = 1'b0;
      if (key_set)
         flag_nxt.key = 1'b1;
      if (req_i.rd && hit)
         flag_nxt.alert = 1'b0;
      if (alert_set)
         flag_nxt.alert = 1'b1;
      if (req_i.rd)
         rdata_nxt = hit ? {flag_r.alert || flag_r.key, flag_r.alert, flag_r.key, rate_r}
                         : KIS_RDATA_RST;
      // pin drive low or port level
      if (rate_r == KIS_RATE_GPO)
         oe_nxt = !gpo_level_i;
      else
         oe_nxt = flag_r.alert || flag_r.key;
   end

   // registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         alert_lvl_r <= 1'b1;
         fifo_empty_q_r <= 1'b1;
         rate_r <= KIS_RATE_RST;
         cnt_r <= '0;
         pend_r <= '0;
         flag_r <= '0;
         rdata_r <= KIS_RDATA_RST;
         oe_r <= 1'b0;
      end
      else if (ce_i)
      begin
         alert_lvl_r <= alert_lvl_nxt;
         fifo_empty_q_r <= fifo_empty_q_nxt;
         rate_r <= rate_nxt;
         cnt_r <= cnt_nxt;
         pend_r <= pend_nxt;
         flag_r <= flag_nxt;
         rdata_r <= rdata_nxt;
         oe_r <= oe_nxt;
      end
   end

   // outputs; pin value is always low, enable does the signalling
   assign rdata_o = rdata_r;
   assign int_oe_o = oe_r;
   always_ff @(posedge clk_i)
   begin
      int_pin_o <= 1'b0;
   end

   // status bit follows the two flags on a read
   AST_STAT_BIT: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && req_i.rd && hit) |=> rdata_o[KIS_STAT_BIT] == $past(flag_r.alert || flag_r.key))
      else $error("status bit wrong after read");
   // cause bits match flags
   AST_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && req_i.rd && hit) |=> (rdata_o[KIS_ALERT_BIT] == $past(flag_r.alert))
         && (rdata_o[KIS_KEY_BIT] == $past(flag_r.key)))
      else $error("cause bits wrong after read");
   // port mode drives the port level
   AST_GPO_PIN: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && rate_r == KIS_RATE_GPO) |=> int_oe_o == !$past(gpo_level_i))
      else $error("pin mode does not follow port bit");
   // port mode updates flags every cycle
   AST_GPO_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && rate_r == KIS_RATE_GPO && dbc_end_i && key_new_i) |=> flag_r.key)
      else $error("key flag missed in pin mode");
   // no key flag off the interval boundary
   AST_RATE_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !flag_r.key && !boundary) |=> !flag_r.key)
      else $error("key flag set off boundary");
   // write leaves status flags alone
   AST_RO_BITS: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && req_i.wr && hit && !req_i.rd && !alert_set && !key_set && !fifo_rise)
         |=> (flag_r == $past(flag_r)) && (rate_r == $past(req_i.wdata[4:0])))
      else $error("write disturbed status flags");
   // read clears alert, keeps key
   AST_READ_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && req_i.rd && hit && !alert_set && !fifo_rise)
         |=> !flag_r.alert && (flag_r.key == $past(flag_r.key || key_set)))
      else $error("read clear wrong");
   // fifo empty clears key flag
   AST_FIFO_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && fifo_rise && !key_set) |=> !flag_r.key)
      else $error("key flag kept after fifo empty");
   // disabled alert raises nothing
   AST_ALERT_EN: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !alert_int_en_i && !pend_r.alert && !flag_r.alert) |=> !flag_r.alert)
      else $error("alert flag without enable");
   // immediate alert sets flag next cycle
   AST_ALERT_NOW: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && alert_fall && alert_int_en_i && alert_int_now_i) |=> flag_r.alert)
      else $error("immediate alert missed");
   // pin enable follows the alert and key flags outside port mode
   AST_PIN_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && rate_r != KIS_RATE_GPO) |=> int_oe_o == $past(flag_r.alert || flag_r.key))
      else $error("pin enable does not follow flags");
   // key flag survives everything but a fifo empty edge
   AST_KEY_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && flag_r.key && !fifo_rise) |=> flag_r.key)
      else $error("key flag lost without fifo empty");
   // alert flag survives until a read of the register
   AST_ALERT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && flag_r.alert && !(req_i.rd && hit)) |=> flag_r.alert)
      else $error("alert flag lost without read");
   // enable low freezes flags, rate, read data and pin
   AST_CE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      !ce_i |=> (flag_r == $past(flag_r)) && (rate_r == $past(rate_r))
         && (rdata_o == $past(rdata_o)) && (int_oe_o == $past(int_oe_o)))
      else $error("state moved while enable low");
endmodule // kis_top
`default_nettype wire

//--- include/kis_pkg.sv
// kis_pkg: shared constants and types of the keypad interrupt status block
// assumes: an 8-bit register port and a 5-bit rate field in the low bits
package kis_pkg;
   // register address and field layout
   localparam logic [7:0] KIS_INT_REG_ADDR = 8'h03;
   localparam int KIS_STAT_BIT = 7;
   localparam int KIS_ALERT_BIT = 6;
   localparam int KIS_KEY_BIT = 5;
   localparam int KIS_RATE_W = 5;
   localparam int KIS_RATE_LSB = 0;
   // reset values, port-mode rate code and rate step
   localparam logic [KIS_RATE_W-1:0] KIS_RATE_RST = 5'h00;
   localparam logic [KIS_RATE_W-1:0] KIS_RATE_GPO = 5'h00;
   localparam logic [KIS_RATE_W-1:0] KIS_RATE_ONE = 5'h01;
   localparam logic [7:0] KIS_RDATA_RST = 8'h00;

   // pending interrupt causes
   typedef struct packed {
      logic alert;
      logic key;
   } kis_cause_s;

   // register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } kis_req_s;
endpackage

//--- sim/kis_host.sv
// kis_host: host side of the interrupt register port
// assumes: requests change on falling clk_i edges only
`timescale 1ns/1ps
`default_nettype none
module kis_host
(
   // clock
   input wire logic clk_i,
   // register port
   output var kis_pkg::kis_req_s req_o,
   input wire logic [7:0] rdata_i
);
   import kis_pkg::*;
   // port idle from time zero
   initial req_o = '0;
   // one write request, held across one rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      req_o.wr = 1'b1;
      req_o.addr = a;
      req_o.wdata = d;
      @(negedge clk_i);
      req_o = '0;
   endtask
   // one read request, data taken once it stands
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      req_o.rd = 1'b1;
      req_o.addr = a;
      @(negedge clk_i);
      req_o = '0;
      d = rdata_i;
   endtask
endmodule // kis_host
`default_nettype wire

//--- sim/testbench.sv
// testbench: register, pin and flag checks of kis_top
// assumes: kis_pkg compiled first, kis_host as register master
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import kis_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic dbc = 1'b0;
   logic knew = 1'b0;
   logic fempty = 1'b1;
   logic aen = 1'b0;
   logic anow = 1'b0;
   logic gpo = 1'b1;
   logic apin = 1'b1;
   logic ce = 1'b1;
   logic int_pin;
   logic int_oe;
   logic [7:0] rdata;
   logic [7:0] v;
   kis_req_s req;
   int num_errors = 0;
   int samples_checked = 0;
   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;
   kis_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .req_i(req), .rdata_o(rdata),
      .dbc_end_i(dbc), .key_new_i(knew), .fifo_empty_i(fempty), .alert_int_en_i(aen),
      .alert_int_now_i(anow), .gpo_level_i(gpo), .alert_pin_i(apin), .int_pin_o(int_pin),
      .int_oe_o(int_oe));
   kis_host host (.clk_i(clk_i), .req_o(req), .rdata_i(rdata));
   // compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] exp);
      host.rd(KIS_INT_REG_ADDR, v);
      chk(v, exp);
   endtask
   task automatic oechk(input logic e);
      repeat (3) @(negedge clk_i);
      chk({7'h00, int_oe}, {7'h00, e});
   endtask
   // one debounce cycle end
   task automatic dbend(input logic k);
      @(negedge clk_i);
      dbc = 1'b1;
      knew = k;
      @(negedge clk_i);
      dbc = 1'b0;
      knew = 1'b0;
      repeat (2) @(negedge clk_i);
   endtask
   task automatic afall;
      @(negedge clk_i);
      apin = 1'b0;
      repeat (8) @(negedge clk_i);
      apin = 1'b1;
      repeat (8) @(negedge clk_i);
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // hang guard
   initial
   begin
      #50000;
      num_errors++;
      complete_run;
   end
   // main sequence
   initial
   begin
      repeat (10) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (6) @(negedge clk_i);
      rdchk(8'h00);
      host.rd(8'h05, v);
      chk(v, 8'h00);
      chk({7'h00, int_pin}, 8'h00);
      gpo = 1'b0;
      oechk(1'b1);
      gpo = 1'b1;
      fempty = 1'b0;
      dbend(1'b1);
      oechk(1'b0);
      rdchk(8'hA0);
      fempty = 1'b1;
      repeat (3) @(negedge clk_i);
      rdchk(8'h00);
      host.wr(KIS_INT_REG_ADDR, 8'hE1);
      rdchk(8'h01);
      fempty = 1'b0;
      dbend(1'b0);
      rdchk(8'h01);
      dbend(1'b1);
      oechk(1'b1);
      rdchk(8'hA1);
      rdchk(8'hA1);
      aen = 1'b1;
      anow = 1'b1;
      afall();
      rdchk(8'hE1);
      rdchk(8'hA1);
      fempty = 1'b1;
      repeat (3) @(negedge clk_i);
      rdchk(8'h01);
      oechk(1'b0);
      anow = 1'b0;
      afall();
      rdchk(8'h01);
      dbend(1'b0);
      rdchk(8'hC1);
      rdchk(8'h01);
      aen = 1'b0;
      afall();
      dbend(1'b0);
      rdchk(8'h01);
      host.wr(KIS_INT_REG_ADDR, 8'h03);
      fempty = 1'b0;
      dbend(1'b1);
      dbend(1'b0);
      rdchk(8'h03);
      dbend(1'b0);
      rdchk(8'hA3);
      ce = 1'b0;
      host.wr(KIS_INT_REG_ADDR, 8'h01);
      ce = 1'b1;
      rdchk(8'hA3);
      complete_run;
   end
endmodule // testbench
`default_nettype wire
